// File: rtl/ppo_pkg.sv
package ppo_pkg;

  localparam int CLK_HZ = 250_000_000;
  localparam int SLOT_MS = 10;
  localparam int SLOT_CYC = CLK_HZ / 1000 * SLOT_MS;
  localparam int SHORT_PPS_US = 20;
  localparam int SHORT_PPS_CYC = CLK_HZ / 1_000_000 * SHORT_PPS_US;
  localparam int F10_HZ = 10_000_000;
  localparam int F5_HZ = 5_000_000;
  localparam int F1_HZ = 1_000_000;
  localparam logic [15:0] DIV_10M = 16'(CLK_HZ / F10_HZ);
  localparam logic [15:0] DIV_5M = 16'(CLK_HZ / F5_HZ);
  localparam logic [15:0] DIV_1M = 16'(CLK_HZ / F1_HZ);
  localparam int MARK0_MS = 100;
  localparam int MARK1_MS = 200;
  localparam int M59_MS = 500;
  localparam logic [9:0] MARK0_SLOTS = 10'(MARK0_MS / SLOT_MS);
  localparam logic [9:0] MARK1_SLOTS = 10'(MARK1_MS / SLOT_MS);
  localparam logic [9:0] M59_SLOTS = 10'(M59_MS / SLOT_MS);
  localparam logic [9:0] LEN_MIN = 10'h001;
  localparam logic [9:0] LEN_MAX = 10'h3e8;
  localparam logic [6:0] CS_LAST = 7'h63;
  localparam logic [6:0] CS_HALF = 7'h32;
  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [4:0] HR_LAST = 5'h17;
  localparam logic [16:0] SOD_LAST = 17'h1517f;
  localparam logic [16:0] SOD_DAY = 17'h15180;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TOD = 8'h04;
  localparam logic [7:0] OFF_LEN = 8'h08;
  localparam logic [7:0] OFF_SHOT = 8'h0c;
  localparam logic [7:0] OFF_CYCLE = 8'h10;
  localparam logic [7:0] OFF_ON0 = 8'h14;
  localparam logic [7:0] OFF_OFF0 = 8'h18;
  localparam logic [7:0] OFF_ON1 = 8'h1c;
  localparam logic [7:0] OFF_OFF1 = 8'h20;
  localparam logic [7:0] OFF_ON2 = 8'h24;
  localparam logic [7:0] OFF_OFF2 = 8'h28;
  localparam logic [7:0] OFF_MARK_LO = 8'h2c;
  localparam logic [7:0] OFF_MARK_HI = 8'h30;
  localparam logic [7:0] OFF_SUSPEND = 8'h34;
  localparam logic [7:0] OFF_SYNTH = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3c;

  localparam int CTRL_POL_BIT = 8;
  localparam logic [9:0] RST_LEN = 10'h00a;
  localparam logic [15:0] RST_SYNTH = 16'h0019;

  typedef enum logic [4:0] {
    MD_IDLE, MD_TIMER, MD_SHOT, MD_CYCLIC, MD_PPS, MD_PPM, MD_PPH,
    MD_MARK, MD_M59, MD_POS, MD_TSYNC, MD_ALLSYNC, MD_DC_LEVEL_SHIFT_CODE,
    MD_F10, MD_SYNTH, MD_SHORT_PPS, MD_F1, MD_F5
  } ppo_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ppo_bus_s;

  typedef struct packed {
    logic pps_s1, pps_s2, pps_d;
    logic pos_s1, pos_s2;
    logic syn_s1, syn_s2;
    logic dcl_s1, dcl_s2;
    logic [21:0] tick;
    logic [6:0] cs;
    logic [5:0] sec;
    logic [5:0] mn;
    logic [4:0] hr;
    logic [16:0] sod;
    logic [16:0] cyc_acc;
    logic [9:0] plen;
    logic [12:0] us_cnt;
    logic [15:0] div_cnt;
    logic [15:0] fr_min;
    logic [4:0] mode;
    logic pol;
    logic [9:0] len;
    logic [16:0] shot;
    logic [16:0] cyc;
    logic [2:0][16:0] ton;
    logic [2:0][16:0] toff;
    logic [58:0] mark;
    logic [15:0] susp;
    logic [15:0] sdiv;
    logic out;
    logic oe;
    logic [31:0] rdata;
  } ppo_state_s;

endpackage

// File: rtl/ppo_channel.sv
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module ppo_channel import ppo_pkg::*; #(
  parameter int SLOT_CYCLES = SLOT_CYC,
  parameter int SHORT_PPS_CYCLES = SHORT_PPS_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire ppo_bus_s bus,
  output logic [31:0] rdata,
  // Timebase and status pins.
  input wire logic pps_in,
  input wire logic pos_ok_in,
  input wire logic time_sync_in,
  input wire logic dc_level_shift_code_in,
  // Signal output.
  output logic sig_out,
  output logic sig_oe
);

  localparam logic [21:0] TICK_LAST = 22'(SLOT_CYCLES - 1);
  localparam logic [12:0] SPPS_LEN = 13'(SHORT_PPS_CYCLES);

  ppo_state_s r;
  ppo_state_s n;
  logic pps_rise;
  logic tick_end;
  logic cs_evt;
  logic sec_adv;
  logic fire;
  logic [9:0] fire_len;
  logic tmr_act;
  logic suspended;
  logic [15:0] div;
  logic [5:0] hh_s;
  logic [5:0] mm_s;

  function automatic logic [16:0] hms_sod(input logic [4:0] h, input logic [5:0] m,
                                          input logic [5:0] s);
    hms_sod = 17'(17'(h) * 17'd3600 + 17'(m) * 17'd60 + 17'(s));
  endfunction

  function automatic logic prog_on(input logic [16:0] t, input logic [16:0] on,
                                   input logic [16:0] off);
    if (on == off) begin
      prog_on = 1'b0;
    end else if (on < off) begin
      prog_on = (t >= on) && (t < off);
    end else begin
      prog_on = (t >= on) || (t < off);
    end
  endfunction

  function automatic logic [9:0] clamp_len(input logic [31:0] v);
    if (v[9:0] < LEN_MIN || v[31:10] != 22'h0) begin
      clamp_len = (v[31:10] != 22'h0) ? LEN_MAX : LEN_MIN;
    end else if (v[9:0] > LEN_MAX) begin
      clamp_len = LEN_MAX;
    end else begin
      clamp_len = v[9:0];
    end
  endfunction

  // Maps the stored mode field onto the mode type for every decoder.
  function automatic ppo_mode_e mode_of(input logic [4:0] m);
    mode_of = ppo_mode_e'(m);
  endfunction

  function automatic logic [16:0] clamp_day(input logic [31:0] v);
    clamp_day = (v > 32'(SOD_DAY)) ? SOD_DAY : v[16:0];
  endfunction

  always_comb begin
    n = r;
    pps_rise = 1'b0;
    tick_end = 1'b0;
    cs_evt = 1'b0;
    sec_adv = 1'b0;
    fire = 1'b0;
    fire_len = r.len;
    tmr_act = 1'b0;
    suspended = 1'b0;
    div = r.sdiv;
    hh_s = 6'h0;
    mm_s = 6'h0;

    // Pin synchronisers.
    n.pps_s1 = pps_in;
    n.pps_s2 = r.pps_s1;
    n.pps_d = r.pps_s2;
    n.pos_s1 = pos_ok_in;
    n.pos_s2 = r.pos_s1;
    n.syn_s1 = time_sync_in;
    n.syn_s2 = r.syn_s1;
    n.dcl_s1 = dc_level_shift_code_in;
    n.dcl_s2 = r.dcl_s1;
    pps_rise = r.pps_s2 & ~r.pps_d;

    // Local time of day in 10 ms slots, realigned by each rising PPS edge.
    tick_end = (r.tick == TICK_LAST);
    cs_evt = tick_end | pps_rise;
    sec_adv = (tick_end && r.cs == CS_LAST) || (pps_rise && r.cs >= CS_HALF);
    n.tick = cs_evt ? 22'h0 : r.tick + 22'h1;
    if (pps_rise) begin
      n.cs = 7'h0;
    end else if (tick_end) begin
      n.cs = (r.cs == CS_LAST) ? 7'h0 : r.cs + 7'h1;
    end
    if (sec_adv) begin
      n.sod = (r.sod >= SOD_LAST) ? 17'h0 : r.sod + 17'h1;
      n.sec = (r.sec == SEC_LAST) ? 6'h0 : r.sec + 6'h1;
      if (r.sec == SEC_LAST) begin
        n.mn = (r.mn == SEC_LAST) ? 6'h0 : r.mn + 6'h1;
        if (r.mn == SEC_LAST) begin
          n.hr = (r.hr == HR_LAST) ? 5'h0 : r.hr + 5'h1;
        end
      end
    end

    // Minutes spent in free run, cleared once sync returns.
    if (r.syn_s2) begin
      n.fr_min = 16'h0;
    end else if (sec_adv && n.sec == 6'h0 && r.fr_min != 16'hffff) begin
      n.fr_min = r.fr_min + 16'h1;
    end
    suspended = (r.susp != 16'h0) && (r.fr_min >= r.susp);

    // Daily timer programs.
    for (int i = 0; i < 3; i++) begin
      tmr_act = tmr_act | prog_on(r.sod, r.ton[i], r.toff[i]);
    end

    // Cyclic pulse counter restarts at midnight.
    if (sec_adv) begin
      if (n.sod == 17'h0 || (r.cyc != 17'h0 && r.cyc_acc + 17'h1 >= r.cyc)) begin
        n.cyc_acc = 17'h0;
      end else begin
        n.cyc_acc = r.cyc_acc + 17'h1;
      end
    end

    // Pulse event selection for the time of day modes.
    case (mode_of(r.mode))
      MD_SHOT: begin
        fire = sec_adv && n.sod == r.shot;
      end
      MD_CYCLIC: begin
        fire = sec_adv && n.cyc_acc == 17'h0;
      end
      MD_PPS: begin
        fire = sec_adv;
      end
      MD_PPM: begin
        fire = sec_adv && n.sec == 6'h0;
      end
      MD_PPH: begin
        fire = sec_adv && n.sec == 6'h0 && n.mn == 6'h0;
      end
      MD_MARK: begin
        fire = sec_adv && n.sec != SEC_LAST && !suspended;
        fire_len = r.mark[n.sec] ? MARK1_SLOTS : MARK0_SLOTS;
      end
      MD_M59: begin
        fire = sec_adv && n.sec == SEC_LAST && !suspended;
        fire_len = M59_SLOTS;
      end
      default: begin
        fire = 1'b0;
      end
    endcase

    // Pulse length counted down in 10 ms slots.
    if (fire) begin
      n.plen = fire_len;
    end else if (cs_evt && r.plen != 10'h0) begin
      n.plen = r.plen - 10'h1;
    end

    // Short PPS width counter.
    if (pps_rise) begin
      n.us_cnt = SPPS_LEN;
    end else if (r.us_cnt != 13'h0) begin
      n.us_cnt = r.us_cnt - 13'h1;
    end

    // Frequency divider, phase reset on PPS so the low half starts there.
    case (mode_of(r.mode))
      MD_F10: div = DIV_10M;
      MD_F5: div = DIV_5M;
      MD_F1: div = DIV_1M;
      default: div = r.sdiv;
    endcase
    if (pps_rise || r.div_cnt + 16'h1 >= div) begin
      n.div_cnt = 16'h0;
    end else begin
      n.div_cnt = r.div_cnt + 16'h1;
    end

    // Software access to the time of day and configuration.
    if (bus.wr) begin
      case (bus.addr)
        OFF_CTRL: begin
          n.mode = bus.wdata[4:0];
          n.pol = bus.wdata[CTRL_POL_BIT];
        end
        OFF_TOD: begin
          hh_s = bus.wdata[21:16];
          mm_s = bus.wdata[13:8];
          n.hr = (hh_s > 6'(HR_LAST)) ? HR_LAST : hh_s[4:0];
          n.mn = (mm_s > SEC_LAST) ? SEC_LAST : mm_s;
          n.sec = (bus.wdata[5:0] > SEC_LAST) ? SEC_LAST : bus.wdata[5:0];
          n.sod = hms_sod(n.hr, n.mn, n.sec);
          n.cs = 7'h0;
          n.tick = 22'h0;
        end
        OFF_LEN: n.len = clamp_len(bus.wdata);
        OFF_SHOT: n.shot = clamp_day(bus.wdata);
        OFF_CYCLE: n.cyc = clamp_day(bus.wdata);
        OFF_ON0: n.ton[0] = clamp_day(bus.wdata);
        OFF_OFF0: n.toff[0] = clamp_day(bus.wdata);
        OFF_ON1: n.ton[1] = clamp_day(bus.wdata);
        OFF_OFF1: n.toff[1] = clamp_day(bus.wdata);
        OFF_ON2: n.ton[2] = clamp_day(bus.wdata);
        OFF_OFF2: n.toff[2] = clamp_day(bus.wdata);
        OFF_MARK_LO: n.mark[31:0] = bus.wdata;
        OFF_MARK_HI: n.mark[58:32] = bus.wdata[26:0];
        OFF_SUSPEND: n.susp = bus.wdata[15:0];
        OFF_SYNTH: n.sdiv = (bus.wdata[15:1] == 15'h0) ? 16'h0002 : bus.wdata[15:0];
        default: begin
          n.mode = r.mode;
        end
      endcase
    end

    // Read data stands for exactly one cycle after the read strobe.
    n.rdata = 32'h0;
    if (bus.rd) begin
      case (bus.addr)
        OFF_CTRL: n.rdata = {23'h0, r.pol, 3'h0, r.mode};
        OFF_TOD: n.rdata = {1'b0, r.cs, 3'h0, r.hr, 2'h0, r.mn, 2'h0, r.sec};
        OFF_LEN: n.rdata = {22'h0, r.len};
        OFF_SHOT: n.rdata = {15'h0, r.shot};
        OFF_CYCLE: n.rdata = {15'h0, r.cyc};
        OFF_ON0: n.rdata = {15'h0, r.ton[0]};
        OFF_OFF0: n.rdata = {15'h0, r.toff[0]};
        OFF_ON1: n.rdata = {15'h0, r.ton[1]};
        OFF_OFF1: n.rdata = {15'h0, r.toff[1]};
        OFF_ON2: n.rdata = {15'h0, r.ton[2]};
        OFF_OFF2: n.rdata = {15'h0, r.toff[2]};
        OFF_MARK_LO: n.rdata = r.mark[31:0];
        OFF_MARK_HI: n.rdata = {5'h0, r.mark[58:32]};
        OFF_SUSPEND: n.rdata = {16'h0, r.susp};
        OFF_SYNTH: n.rdata = {16'h0, r.sdiv};
        OFF_STATUS: n.rdata = {27'h0, suspended, r.syn_s2, r.pos_s2, r.oe, r.out};
        default: n.rdata = 32'h0;
      endcase
    end

    // Output level per mode.
    n.oe = 1'b1;
    case (mode_of(r.mode))
      MD_IDLE: begin
        n.out = 1'b0;
        n.oe = 1'b0;
      end
      MD_TIMER: n.out = tmr_act ^ r.pol;
      MD_SHOT, MD_CYCLIC, MD_PPS, MD_PPM, MD_PPH, MD_MARK, MD_M59: begin
        n.out = (n.plen != 10'h0);
      end
      MD_POS: n.out = r.pos_s2;
      MD_TSYNC: n.out = r.syn_s2;
      MD_ALLSYNC: n.out = r.pos_s2 & r.syn_s2;
      MD_DC_LEVEL_SHIFT_CODE: n.out = r.dcl_s2;
      MD_F10, MD_F5, MD_F1, MD_SYNTH: begin
        n.out = (n.div_cnt >= (div >> 1));
      end
      MD_SHORT_PPS: n.out = (n.us_cnt != 13'h0);
      default: begin
        n.out = 1'b0;
        n.oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.len <= RST_LEN;
      r.sdiv <= RST_SYNTH;
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign sig_out = r.out;
  assign sig_oe = r.oe;

endmodule // ppo_channel

// File: verif/ppo_channel_sva.sv
`timescale 1ns/1ps
module ppo_channel_sva import ppo_pkg::*; #(
  parameter int SLOT_CYCLES = SLOT_CYC,
  parameter int SHORT_PPS_CYCLES = SHORT_PPS_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire ppo_bus_s bus,
  input wire logic [31:0] rdata,
  // Timebase and status pins.
  input wire logic pps_in,
  input wire logic pos_ok_in,
  input wire logic time_sync_in,
  input wire logic dc_level_shift_code_in,
  // Signal output.
  input wire logic sig_out,
  input wire logic sig_oe
);
  logic [4:0] mode_r;
  int hi_r;
  logic idle;
  assign idle = (mode_r == 5'h00) || (mode_r > 5'h11);
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= 5'h00;
    end else if (bus.wr && bus.addr == OFF_CTRL) begin
      mode_r <= bus.wdata[4:0];
    end
    hi_r <= sig_out ? hi_r + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    rst |=> !sig_oe && !sig_out && rdata == 32'h0) else $error("outputs active after reset");
  AST_RDATA_ZERO: assert property (!bus.rd |=> rdata == 32'h0)
    else $error("read data without read");
  AST_IDLE_QUIET: assert property (idle [*3] |-> !sig_oe && !sig_out)
    else $error("idle output driven");
  AST_OE_ACTIVE: assert property (!idle [*3] |-> sig_oe)
    else $error("output not enabled");
  AST_POS_FOLLOW: assert property ((mode_r == 5'h09 && pos_ok_in) [*5] |-> sig_out)
    else $error("position indication missing");
  AST_TSYNC_FOLLOW: assert property (
    (mode_r == 5'h0a) throughout (!time_sync_in [*5]) |-> !sig_out) else $error("sync shown");
  AST_ALL_SYNC: assert property (
    (mode_r == 5'h0b && $stable({pos_ok_in, time_sync_in})) [*5]
    |-> sig_out == (pos_ok_in && time_sync_in)) else $error("combined sync wrong");
  AST_FREQ_ALIGN: assert property (
    (mode_r inside {5'h0d, 5'h0e, 5'h10, 5'h11}) && $rose(pps_in) |-> ##5 (!sig_out) [*8])
    else $error("frequency not low after pps");
  AST_SHORT_PPS_WIDTH: assert property (
    mode_r == 5'h0f && $fell(sig_out) |-> hi_r == SHORT_PPS_CYCLES)
    else $error("short pps width wrong");
  cover property (mode_r == 5'h0f && $fell(sig_out));
  cover property (mode_r == 5'h0b && sig_out);
  cover property (mode_r == 5'h0d && $rose(pps_in));
  cover property (mode_r == 5'h01 && sig_out);
endmodule // ppo_channel_sva

bind ppo_channel ppo_channel_sva #(
  .SLOT_CYCLES(SLOT_CYCLES),
  .SHORT_PPS_CYCLES(SHORT_PPS_CYCLES)
) u_sva (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .pps_in(pps_in),
  .pos_ok_in(pos_ok_in), .time_sync_in(time_sync_in),
  .dc_level_shift_code_in(dc_level_shift_code_in),
  .sig_out(sig_out), .sig_oe(sig_oe));

// File: verif/ppo_rx_model.sv
`timescale 1ns/1ps
module ppo_rx_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Received signal.
  input wire logic sig_out,
  input wire logic sig_oe,
  // Last complete run lengths in cycles.
  output int hi_len,
  output int lo_len
);
  int run;
  logic last;
  // The receiver only measures while the line is driven.
  always @(posedge clk) begin
    if (rst || !sig_oe) begin
      run <= 0;
      last <= 1'b0;
    end else if (sig_out != last) begin
      if (last) begin
        hi_len <= run;
      end else begin
        lo_len <= run;
      end
      run <= 1;
      last <= sig_out;
    end else begin
      run <= run + 1;
    end
  end
endmodule // ppo_rx_model

// File: verif/ppo_channel_bench.sv
`timescale 1ns/1ps
module ppo_channel_bench import ppo_pkg::*;;
  localparam int SLOT = 100;
  localparam int SPPS = 20;
  localparam logic [4:0] FMD [4] = '{5'h0d, 5'h11, 5'h10, 5'h0e};
  localparam logic [15:0] SYN_DIV = 16'h0020;
  localparam logic [15:0] FDV [4] = '{DIV_10M, DIV_5M, DIV_1M, SYN_DIV};
  logic clk = 1'b0;
  logic rst = 1'b1;
  ppo_bus_s bus = '0;
  logic [31:0] rdata;
  logic pps_in = 1'b0;
  logic pos_ok_in = 1'b0;
  logic time_sync_in = 1'b0;
  logic dc_level_shift_code_in = 1'b0;
  logic sig_out;
  logic sig_oe;
  int hi_len;
  int lo_len;
  int error_cnt = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  ppo_channel #(.SLOT_CYCLES(SLOT), .SHORT_PPS_CYCLES(SPPS)) dut (.clk(clk), .rst(rst),
    .bus(bus), .rdata(rdata), .pps_in(pps_in), .pos_ok_in(pos_ok_in),
    .time_sync_in(time_sync_in), .dc_level_shift_code_in(dc_level_shift_code_in),
    .sig_out(sig_out), .sig_oe(sig_oe));
  ppo_rx_model rx (.clk(clk), .rst(rst), .sig_out(sig_out), .sig_oe(sig_oe),
    .hi_len(hi_len), .lo_len(lo_len));
  task results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp, msg);
  endtask
  task pulse_pps;
    @(posedge clk);
    pps_in <= 1'b1;
    cyc(5);
    pps_in <= 1'b0;
  endtask
  task wait_fall(input int bound);
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < bound; i++) begin
      @(posedge clk);
      if (sig_out === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    if (i == bound) begin
      error_cnt++;
      $display("wrong value at %0t: no pulse end", $time);
      results;
    end
  endtask
  task t_reset;
    #1 chk(32'(sig_oe), 32'h0, "oe after reset");
    rd(OFF_LEN, 32'(RST_LEN), "len reset");
    rd(OFF_SYNTH, 32'(RST_SYNTH), "synth reset");
    rd(8'h40, 32'h0, "unmapped");
    wr(OFF_LEN, 32'h0);
    rd(OFF_LEN, 32'(LEN_MIN), "len min");
    wr(OFF_LEN, 32'h7d0);
    rd(OFF_LEN, 32'(LEN_MAX), "len max");
    $display("done: registers");
  endtask
  task t_sync;
    logic [4:0] m;
    logic e;
    for (int i = 0; i < 16; i++) begin
      m = 5'h09 + 5'(i[3:2]);
      wr(OFF_CTRL, 32'(m));
      pos_ok_in <= i[0];
      time_sync_in <= i[1];
      dc_level_shift_code_in <= i[0] ^ i[1];
      cyc(8);
      case (m)
        5'h09: e = i[0];
        5'h0a: e = i[1];
        5'h0b: e = i[0] & i[1];
        default: e = i[0] ^ i[1];
      endcase
      #1 chk(32'(sig_out), 32'(e), "status output");
    end
    $display("done: status modes");
  endtask
  task t_freq;
    wr(OFF_SYNTH, 32'h1);
    rd(OFF_SYNTH, 32'h2, "synth min");
    wr(OFF_SYNTH, 32'(SYN_DIV));
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CTRL, 32'(FMD[k]));
      pulse_pps;
      cyc(700);
      #1 chk(32'(lo_len), 32'(FDV[k] / 2), "low run");
      chk(32'(hi_len), 32'(FDV[k] - FDV[k] / 2), "high run");
    end
    $display("done: frequencies");
  endtask
  task t_pulses;
    wr(OFF_CTRL, 32'h00);
    cyc(2);
    wr(OFF_CTRL, 32'h0f);
    pulse_pps;
    wait_fall(100);
    cyc(2);
    chk(32'(hi_len), 32'(SPPS), "short pps");
    wr(OFF_LEN, 32'h1);
    wr(OFF_CTRL, 32'h04);
    wait_fall(12000);
    cyc(2);
    chk(32'(hi_len), 32'(SLOT), "second pulse");
    $display("done: pulses");
  endtask
  task t_marks;
    wr(OFF_MARK_HI, 32'h04000000);
    wr(OFF_TOD, 32'h00000039);
    wr(OFF_CTRL, 32'h07);
    wait_fall(13000);
    cyc(2);
    chk(32'(hi_len), 32'(MARK1_SLOTS) * SLOT, "mark one");
    cyc(8500);
    #1 chk(32'(sig_out), 32'h0, "no mark at 59");
    wait_fall(12000);
    cyc(2);
    chk(32'(hi_len), 32'(MARK0_SLOTS) * SLOT, "mark zero");
    wr(OFF_LEN, 32'h1);
    wr(OFF_SHOT, 32'h3);
    wr(OFF_TOD, 32'h00000002);
    wr(OFF_CTRL, 32'h02);
    wait_fall(11000);
    cyc(2);
    chk(32'(hi_len), 32'(SLOT), "single shot");
    $display("done: marks and shot");
  endtask
  task t_timer;
    logic [3:0] act;
    act = 4'b1011;
    wr(OFF_CTRL, 32'h101);
    wr(OFF_ON0, 32'h1517f);
    wr(OFF_OFF0, 32'h1);
    wr(OFF_ON1, 32'h64);
    wr(OFF_OFF1, 32'h64);
    wr(OFF_ON2, 32'h2);
    wr(OFF_OFF2, 32'h3);
    wr(OFF_TOD, 32'h00173b3b);
    for (int i = 0; i < 4; i++) begin
      cyc(i == 0 ? 5000 : 10000);
      #1 chk(32'(sig_out), 32'(!act[i]), "timer inverted");
    end
    wr(OFF_CTRL, 32'h1);
    cyc(4);
    #1 chk(32'(sig_out), 32'h1, "timer normal");
    wr(OFF_CTRL, 32'h12);
    cyc(4);
    #1 chk(32'(sig_oe), 32'h0, "idle");
    $display("done: timer and idle");
  endtask
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    t_reset;
    t_sync;
    t_freq;
    t_pulses;
    t_timer;
    t_marks;
    results;
  end
endmodule // ppo_channel_bench
